/* verilog/cca_pkg.sv */
`default_nettype none
package cca_pkg;
  // Word indices of the registers; the byte address is four times the index.
  localparam logic [5:0] A_TCTRL = 6'h00;
  localparam logic [5:0] A_TMR0  = 6'h01;
  localparam logic [5:0] A_RLD0  = 6'h02;
  localparam logic [5:0] A_ISTS  = 6'h05;
  localparam logic [5:0] A_IMSK  = 6'h06;
  localparam logic [5:0] A_PINS  = 6'h07;
  localparam logic [5:0] A_CCFG  = 6'h10;
  localparam logic [5:0] A_CVAL  = 6'h20;
  // Timer control layout: four bits per timer, stagger bit above them.
  localparam int TC_WIDTH = 4;
  localparam int TC_RUN   = 0;
  localparam int TC_SEL   = 1;
  localparam int TC_STG   = 8;
  // Channel configuration layout.
  localparam int CF_MODE  = 0;
  localparam int CF_EDGE  = 3;
  localparam int CF_TSEL  = 5;
  localparam int CF_ONCE  = 6;
  localparam int CF_WIDTH = 7;
  localparam int NCH      = 16;
  localparam int NHALF    = 8;
  localparam int PRE_W    = 12;
  localparam int PRE_STEP = 3;
  localparam logic [15:0] TMR_TOP = 16'hffff;
  localparam logic [31:0] RST_TCTRL = 32'h0000_0000;
  localparam logic [15:0] RST_IMSK  = 16'h0000;
  localparam logic [6:0]  RST_CCFG  = 7'h00;
  typedef enum logic [2:0] {
    CCA_OFF  = 3'h0,
    CCA_CAP  = 3'h1,
    CCA_CMP0 = 3'h2,
    CCA_CMP1 = 3'h3,
    CCA_CMP2 = 3'h4,
    CCA_CMP3 = 3'h5,
    CCA_DBL  = 3'h6
  } cca_mode_e;
  typedef enum logic [2:0] {
    CCA_CLK1   = 3'h0,
    CCA_CLK8   = 3'h1,
    CCA_CLK64  = 3'h2,
    CCA_CLK512 = 3'h3,
    CCA_AUX    = 3'h4,
    CCA_EXT    = 3'h5
  } cca_csel_e;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
endpackage : cca_pkg
`default_nettype wire

/* verilog/cca_unit.sv */
// Function
// [R1] Sixteen independent capture/compare channels generate and control timing sequences.
// [R2] Resolution is one clock; staggered option coarsens it to eight clocks.
// [R3] Two 16-bit timers, each with its own reload register, are the time bases.
// [R4] Timer clock is a prescaled system clock or the auxiliary timer overflow pulse.
// [R5] Timers can also count external count inputs.
// [R6] Each channel selects either timer and capture or compare function.
// [R7] Each channel owns one pin: capture input or compare output.
// [R8] Capture copies the allocated timer into the channel register on the pin event.
// [R9] Every capture raises that channel's interrupt request.
// [R10] Capture trigger is rising, falling or both edges, per channel.
// [R11] Compare channels match against their timer on every count and act on equality.
// [R12] Mode 0: interrupt only, several per timer period.
// [R13] Mode 1: pin toggles on every match, several per period.
// [R14] Mode 2: interrupt only, at most one per timer period.
// [R15] Mode 3: pin set on match, cleared on timer overflow, one per period.
// [R16] Double register mode: two registers share one pin, either match toggles it.
// [R17] Single event option lets any compare mode give one edge or pulse only; the code drops pin_oe on that event, so a new pin level is never driven.
// [R18] On overflow a timer reloads from its reload register and keeps counting.
`timescale 1ns/1ps
`default_nettype none
module cca_unit (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Avalon-MM slave
  input  wire logic [5:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  // Count sources
  input  wire logic         aux_timer_ovf,
  input  wire logic [1:0]   ext_count,
  // Channel pins
  input  wire logic [15:0]  pin_in,
  output logic      [15:0]  pin_out,
  output logic      [15:0]  pin_oe,
  // Interrupt
  output logic              irq
);

  typedef struct packed {
    logic [cca_pkg::PRE_W-1:0]                   pre;
    logic [1:0][15:0]                            tmr;
    logic [1:0][15:0]                            rld;
    logic [31:0]                                 tctrl;
    logic [1:0]                                  cnt_d;
    logic [1:0]                                  ovf_d;
    logic [1:0]                                  ext_d;
    logic [cca_pkg::NCH-1:0][15:0]               cval;
    logic [cca_pkg::NCH-1:0][cca_pkg::CF_WIDTH-1:0] ccfg;
    logic [15:0]                                 done;
    logic [15:0]                                 pin;
    logic [15:0]                                 pin_d;
    logic [15:0]                                 ists;
    logic [15:0]                                 imsk;
    logic                                        ack;
    logic [31:0]                                 rdata;
  } cca_state_s;

  cca_state_s st_r;
  cca_state_s st_nxt;

  function automatic logic [31:0] cca_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : cca_merge

  always_comb begin
    logic [3:0]         tc;
    logic [3:0]         n;
    logic [cca_pkg::PRE_W-1:0] msk;
    logic [1:0]         tick;
    logic [15:0]        ev;
    logic [31:0]        m32;
    logic [2:0]         md;
    logic               ts;
    logic               hit;
    logic               mt;
    logic [3:0]         pi;
    logic [1:0]         eg;
    tc     = 4'h0;
    n      = 4'h0;
    msk    = '0;
    tick   = 2'h0;
    ev     = 16'h0000;
    m32    = 32'h0000_0000;
    md     = 3'h0;
    ts     = 1'b0;
    hit    = 1'b0;
    mt     = 1'b0;
    pi     = 4'h0;
    eg     = 2'h0;
    st_nxt = st_r;
    st_nxt.pre   = st_r.pre + 12'h001;
    st_nxt.ext_d = ext_count;
    st_nxt.pin_d = pin_in;

    // Time bases.
    for (int t = 0; t < 2; t++) begin
      tc = st_r.tctrl[t*cca_pkg::TC_WIDTH +: cca_pkg::TC_WIDTH];
      // Prescaled ticks: the divider is 8 to the power of the select, and
      // staggered operation multiplies it by a further eight.
      n = 4'(tc[cca_pkg::TC_SEL +: 3] * cca_pkg::PRE_STEP);
      if (st_r.tctrl[cca_pkg::TC_STG]) begin
        n = n + 4'(cca_pkg::PRE_STEP); // R2
      end
      // One free-running prescaler serves both timers, so the first tick after
      // a start can come early by up to one divider period.
      msk = cca_pkg::PRE_W'((1 << n) - 1);
      unique case (tc[cca_pkg::TC_SEL +: 3])
        cca_pkg::CCA_CLK1, cca_pkg::CCA_CLK8,
        cca_pkg::CCA_CLK64, cca_pkg::CCA_CLK512: begin
          tick[t] = &(st_r.pre | ~msk); // R4
        end
        cca_pkg::CCA_AUX: begin
          tick[t] = aux_timer_ovf; // R4
        end
        cca_pkg::CCA_EXT: begin
          // The external input is taken as synchronous; only its rising edge counts.
          tick[t] = ext_count[t] & ~st_r.ext_d[t]; // R5
        end
        default: begin
          tick[t] = 1'b0;
        end
      endcase
      st_nxt.cnt_d[t] = 1'b0;
      st_nxt.ovf_d[t] = 1'b0;
      if (tc[cca_pkg::TC_RUN] && tick[t]) begin
        st_nxt.cnt_d[t] = 1'b1;
        if (st_r.tmr[t] == cca_pkg::TMR_TOP) begin
          st_nxt.tmr[t]   = st_r.rld[t]; // R18
          st_nxt.ovf_d[t] = 1'b1;
        end else begin
          st_nxt.tmr[t] = st_r.tmr[t] + 16'h0001; // R3
        end
      end
    end

    // Register bus: one wait state, the access completes when ack is high.
    st_nxt.ack = (avs_read || avs_write) && !st_r.ack;
    if ((avs_read || avs_write) && !st_r.ack) begin
      st_nxt.rdata = 32'h0000_0000;
      // Read data is latched in the wait cycle so that it comes from a flop;
      // words that no register claims read as zero.
      case (avs_address)
        cca_pkg::A_TCTRL: begin
          st_nxt.rdata = st_r.tctrl;
        end
        cca_pkg::A_ISTS: begin
          st_nxt.rdata = {16'h0000, st_r.ists};
        end
        cca_pkg::A_IMSK: begin
          st_nxt.rdata = {16'h0000, st_r.imsk};
        end
        cca_pkg::A_PINS: begin
          st_nxt.rdata = {16'h0000, st_r.pin};
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
      for (int t = 0; t < 2; t++) begin
        if (avs_address == 6'(cca_pkg::A_TMR0 + 2*t)) begin
          st_nxt.rdata = {16'h0000, st_r.tmr[t]};
        end
        if (avs_address == 6'(cca_pkg::A_RLD0 + 2*t)) begin
          st_nxt.rdata = {16'h0000, st_r.rld[t]};
        end
      end
      for (int i = 0; i < cca_pkg::NCH; i++) begin
        if (avs_address == 6'(cca_pkg::A_CCFG + i)) begin
          st_nxt.rdata = {25'h0000000, st_r.ccfg[i]};
        end
        if (avs_address == 6'(cca_pkg::A_CVAL + i)) begin
          st_nxt.rdata = {16'h0000, st_r.cval[i]};
        end
      end
    end
    // Writes take effect at the edge after the wait cycle, the one where the bus
    // master samples waitrequest low.
    if (avs_write && st_r.ack) begin
      m32 = cca_merge(32'h0000_0000, avs_writedata, avs_byteenable);
      if (avs_address == cca_pkg::A_TCTRL) begin
        st_nxt.tctrl = cca_merge(st_r.tctrl, avs_writedata, avs_byteenable) & 32'h0000_01ff;
      end
      // Status bits are write-one-to-clear; the event merge below keeps a
      // coincident set.
      if (avs_address == cca_pkg::A_ISTS) begin
        st_nxt.ists = st_r.ists & ~m32[15:0];
      end
      if (avs_address == cca_pkg::A_IMSK) begin
        st_nxt.imsk = 16'(cca_merge({16'h0000, st_r.imsk}, avs_writedata, avs_byteenable));
      end
      for (int t = 0; t < 2; t++) begin
        // A software write to a timer wins over a count in the same cycle.
        if (avs_address == 6'(cca_pkg::A_TMR0 + 2*t)) begin
          st_nxt.tmr[t] = 16'(cca_merge({16'h0000, st_r.tmr[t]}, avs_writedata, avs_byteenable));
        end
        if (avs_address == 6'(cca_pkg::A_RLD0 + 2*t)) begin
          st_nxt.rld[t] = 16'(cca_merge({16'h0000, st_r.rld[t]}, avs_writedata, avs_byteenable));
        end
      end
      for (int i = 0; i < cca_pkg::NCH; i++) begin
        if (avs_address == 6'(cca_pkg::A_CCFG + i)) begin
          st_nxt.ccfg[i] = cca_pkg::CF_WIDTH'(cca_merge({25'h0000000, st_r.ccfg[i]}, avs_writedata,
                                                         avs_byteenable)); // R6
          st_nxt.done[i] = 1'b0;
        end
        if (avs_address == 6'(cca_pkg::A_CVAL + i)) begin
          st_nxt.cval[i] = 16'(cca_merge({16'h0000, st_r.cval[i]}, avs_writedata, avs_byteenable));
        end
      end
    end

    // Channels. Hardware events override bus writes in the same cycle.
    for (int i = 0; i < cca_pkg::NCH; i++) begin // R1
      md = st_r.ccfg[i][cca_pkg::CF_MODE +: 3];
      ts = st_r.ccfg[i][cca_pkg::CF_TSEL]; // R6
      eg = st_r.ccfg[i][cca_pkg::CF_EDGE +: 2];
      pi = 4'(i + cca_pkg::NHALF);
      // A timer overflow opens a new period: the once-per-period flag is
      // rearmed for the next cycle and a mode 3 pin returns low; a match in this cycle still tests the old flag.
      if (st_r.ovf_d[ts]) begin
        st_nxt.done[i] = 1'b0; // R14
        if (md == cca_pkg::CCA_CMP3) begin
          st_nxt.pin[i] = 1'b0; // R15
        end
      end
      // The edge detector samples every pin each cycle in any mode, so a pin that is
      // already high when capture is enabled reads as no edge.
      hit = (eg[0] && pin_in[i] && !st_r.pin_d[i]) || (eg[1] && !pin_in[i] && st_r.pin_d[i]); // R10
      // Compare only on the cycle after a count, so each timer value is seen once.
      mt = st_r.cnt_d[ts] && (st_r.tmr[ts] == st_r.cval[i]); // R11
      // In double register mode the lower channel also watches its partner
      // eight places up; the upper channel's own mode is left to software.
      if (md == cca_pkg::CCA_DBL && i < cca_pkg::NHALF) begin
        mt = mt || (st_r.cnt_d[ts] && st_r.tmr[ts] == st_r.cval[pi]); // R16
      end
      unique case (md)
        cca_pkg::CCA_CAP: begin
          if (hit) begin
            st_nxt.cval[i] = st_r.tmr[ts]; // R8
            ev[i] = 1'b1; // R9
          end
        end
        cca_pkg::CCA_CMP0: begin
          ev[i] = mt; // R12
        end
        cca_pkg::CCA_CMP1: begin
          if (mt) begin
            st_nxt.pin[i] = ~st_r.pin[i]; // R13
            ev[i] = 1'b1;
          end
        end
        cca_pkg::CCA_CMP2: begin
          if (mt && !st_r.done[i]) begin
            st_nxt.done[i] = 1'b1; // R14
            ev[i] = 1'b1;
          end
        end
        cca_pkg::CCA_CMP3: begin
          if (mt && !st_r.done[i]) begin
            st_nxt.done[i] = 1'b1;
            st_nxt.pin[i]  = 1'b1; // R15
            ev[i] = 1'b1;
          end
        end
        cca_pkg::CCA_DBL: begin
          if (mt && i < cca_pkg::NHALF) begin
            st_nxt.pin[i] = ~st_r.pin[i]; // R16
            ev[i] = 1'b1;
          end
        end
        default: begin
          ev[i] = 1'b0;
        end
      endcase
      // A single event channel switches itself off and releases its pin; pin_out keeps the new level;
      // software rearms it by writing the mode again.
      if (ev[i] && md != cca_pkg::CCA_CAP && st_r.ccfg[i][cca_pkg::CF_ONCE]) begin
        st_nxt.ccfg[i][cca_pkg::CF_MODE +: 3] = cca_pkg::CCA_OFF; // R17
      end
    end
    // Set wins over a write-one-to-clear in the same cycle.
    st_nxt.ists = st_nxt.ists | ev;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r.pre   <= '0;
      st_r.tmr   <= '0;
      st_r.rld   <= '0;
      st_r.tctrl <= cca_pkg::RST_TCTRL;
      st_r.cnt_d <= 2'h0;
      st_r.ovf_d <= 2'h0;
      st_r.ext_d <= 2'h0;
      st_r.cval  <= '0;
      st_r.ccfg  <= {cca_pkg::NCH{cca_pkg::RST_CCFG}};
      st_r.done  <= 16'h0000;
      st_r.pin   <= 16'h0000;
      st_r.pin_d <= 16'h0000;
      st_r.ists  <= 16'h0000;
      st_r.imsk  <= cca_pkg::RST_IMSK;
      st_r.ack   <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin direction follows the channel mode; capture and interrupt-only
  // modes leave the pin to the outside world.
  always_comb begin
    logic [2:0] md;
    md = 3'h0;
    for (int i = 0; i < cca_pkg::NCH; i++) begin
      md = st_r.ccfg[i][cca_pkg::CF_MODE +: 3];
      case (md)
        cca_pkg::CCA_CMP1, cca_pkg::CCA_CMP3: begin
          pin_oe[i] = 1'b1; // R7
        end
        cca_pkg::CCA_DBL: begin
          // Only the lower half drives in double register mode.
          pin_oe[i] = (i < cca_pkg::NHALF); // R7
        end
        default: begin
          pin_oe[i] = 1'b0;
        end
      endcase
    end
  end

  assign pin_out         = st_r.pin;
  assign avs_readdata    = st_r.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
  assign irq             = |(st_r.ists & st_r.imsk);

endmodule : cca_unit
`default_nettype wire

/* tb/cca_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cca_pin_model (
  // Design side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  // Bench side
  input  wire logic [15:0] drive_lvl,
  output logic      [15:0] pin_in
);
  // A driven pin reads back its own level, so a compare output never captures by accident.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive_lvl);
endmodule : cca_pin_model
`default_nettype wire

/* tb/cca_unit_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module cca_unit_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Count sources, pins and interrupt
  input wire logic        aux_timer_ovf,
  input wire logic [1:0]  ext_count,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic        irq
);
  wire logic req = avs_read || avs_write;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wait_once_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait lasted more than one cycle");
  wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("new request got no wait cycle");
  idle_nowait_a: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised while idle");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 6'h08 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  pin_read_a: assert property (avs_read && !avs_waitrequest && avs_address == cca_pkg::A_PINS
    |-> avs_readdata == {16'h0, $past(pin_out)})
    else $error("pin register differs from pins");
  pin_drive_a: assert property (((pin_out ^ $past(pin_out)) & ~$past(pin_oe)) == 16'h0)
    else $error("undriven pin changed level");
  irq_clear_a: assert property ($fell(irq) |-> $past(avs_write))
    else $error("interrupt dropped without a write");
  rdata_hold_a: assert property (!req |=> $stable(avs_readdata))
    else $error("read data changed while idle");
  reset_quiet_a: assert property (disable iff (1'b0) rst |-> pin_out == 16'h0 && !irq)
    else $error("outputs active in reset");
  cover property ($rose(irq));
  cover property ($fell(pin_out[4]));
  cover property (avs_read && !avs_waitrequest && avs_address == 6'h08);
endmodule : cca_unit_chk
bind cca_unit cca_unit_chk u_chk (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .aux_timer_ovf(aux_timer_ovf),
  .ext_count(ext_count), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock = 1'b0;
  logic        rst = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        aux_timer_ovf = 1'b0;
  logic [1:0]  ext_count = 2'h0;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [15:0] drive_lvl = 16'h0;
  logic [15:0] cv [5] = '{16'hfffb, 16'hfffc, 16'hfffa, 16'hfffa, 16'hfffd};
  logic [6:0]  cf [5] = '{7'h03, 7'h05, 7'h04, 7'h02, 7'h43};
  int          n_mismatch = 0;
  int          samples_checked = 0;
  always #25 clock = ~clock;
  cca_unit DUT (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .aux_timer_ovf(aux_timer_ovf),
    .ext_count(ext_count), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  cca_pin_model PINS (.pin_out(pin_out), .pin_oe(pin_oe), .drive_lvl(drive_lvl), .pin_in(pin_in));
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // Waitrequest and read data are taken at the rising edge, before the registers there update.
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) n_mismatch++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic tick(input int n, input bit ext);
    repeat (n) begin
      @(posedge clock);
      ext_count[1] <= ext;
      aux_timer_ovf <= ~ext;
      @(posedge clock);
      ext_count[1] <= 1'b0;
      aux_timer_ovf <= 1'b0;
    end
    repeat (3) @(posedge clock);
  endtask : tick
  task automatic irq_is(input logic e);
    @(negedge clock);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irq_is
  initial begin
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(cca_pkg::A_TCTRL, 32'h0);
    rd(cca_pkg::A_IMSK, 32'h0);
    rd(cca_pkg::A_CCFG, 32'h0);
    rd(6'h08, 32'h0);
    wr(cca_pkg::A_TMR0, 32'h1234);
    wr(cca_pkg::A_CCFG + 6'h2, 32'h9);
    wr(cca_pkg::A_IMSK, 32'h4);
    @(posedge clock);
    drive_lvl[2] <= 1'b1;
    repeat (3) @(posedge clock);
    irq_is(1'b1);
    rd(cca_pkg::A_CVAL + 6'h2, 32'h1234);
    rd(cca_pkg::A_ISTS, 32'h4);
    wr(cca_pkg::A_IMSK, 32'h0);
    irq_is(1'b0);
    wr(cca_pkg::A_ISTS, 32'h4);
    wr(cca_pkg::A_IMSK, 32'h4);
    irq_is(1'b0);
    @(posedge clock);
    drive_lvl[2] <= 1'b0;
    repeat (3) @(posedge clock);
    rd(cca_pkg::A_ISTS, 32'h0);
    wr(cca_pkg::A_RLD0, 32'hfff0);
    wr(cca_pkg::A_TMR0, 32'hfff8);
    for (int i = 0; i < 5; i++) begin
      wr(cca_pkg::A_CVAL + 6'(i + 3), {16'h0, cv[i]});
      wr(cca_pkg::A_CCFG + 6'(i + 3), {25'h0, cf[i]});
    end
    wr(cca_pkg::A_TCTRL, 32'hb9);
    tick(5, 1'b0);
    rd(cca_pkg::A_PINS, 32'h98);
    rd(cca_pkg::A_ISTS, 32'hf8);
    chk({16'h0, pin_oe}, 32'h18);
    rd(cca_pkg::A_CCFG + 6'h7, 32'h40);
    wr(cca_pkg::A_ISTS, 32'hff);
    wr(cca_pkg::A_TMR0, 32'hfff9);
    tick(1, 1'b0);
    rd(cca_pkg::A_ISTS, 32'h40);
    tick(6, 1'b0);
    rd(cca_pkg::A_TMR0, 32'hfff0);
    rd(cca_pkg::A_PINS, 32'h80);
    rd(cca_pkg::A_ISTS, 32'h48);
    wr(cca_pkg::A_ISTS, 32'hff);
    tick(10, 1'b0);
    rd(cca_pkg::A_ISTS, 32'h60);
    tick(3, 1'b1);
    rd(6'h03, 32'h3);
    wr(cca_pkg::A_CVAL, 32'h5);
    wr(cca_pkg::A_CVAL + 6'h8, 32'h7);
    wr(cca_pkg::A_CCFG, 32'h26);
    tick(2, 1'b1);
    chk({16'h0, pin_oe}, 32'h19);
    rd(cca_pkg::A_PINS, 32'h81);
    tick(2, 1'b1);
    rd(cca_pkg::A_PINS, 32'h80);
    rd(cca_pkg::A_ISTS, 32'h61);
    wr(cca_pkg::A_TCTRL, 32'hb3);
    wr(cca_pkg::A_TMR0, 32'h0);
    repeat (63) @(posedge clock);
    rd(cca_pkg::A_TMR0, 32'h8);
    wr(cca_pkg::A_TCTRL, 32'h1b3);
    wr(cca_pkg::A_TMR0, 32'h0);
    repeat (63) @(posedge clock);
    rd(cca_pkg::A_TMR0, 32'h1);
    wr(cca_pkg::A_CCFG + 6'h2, 32'h11);
    wr(cca_pkg::A_ISTS, 32'hff);
    @(posedge clock);
    drive_lvl[2] <= 1'b1;
    repeat (3) @(posedge clock);
    rd(cca_pkg::A_ISTS, 32'h0);
    drive_lvl[2] <= 1'b0;
    repeat (3) @(posedge clock);
    rd(cca_pkg::A_ISTS, 32'h4);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    final_report();
  end
endmodule : tb
`default_nettype wire
